//--- hw/pfm_pkg.sv
// Constants, register map and pin function decoding for the upper port pin multiplexer.
// Assumes an APB4 slave port on pclk and a 32-pin general-purpose port.
// Summary of operation
// [RL1] Select register gives pins 16..31 two-bit fields, all zero after reset.
// [RL2] Direction register steers a pin only while its field selects plain port I/O.
// [RL3] Primary debug ports are enabled only by the debug-select level caught at reset; JTAG inputs from pins 27..30 pass before it is caught.
// [RL4] Fields of pins 17..31 act only when debug-select was low at reset.
// [RL5] Value 01 routes pin 17 to timer-1 capture 2, pin 18 to capture 3.
// [RL6] One write sets chosen outputs, another clears chosen outputs, others unchanged.
// [RL7] Output register reads back; pin levels read separately.
// [RL8] All port pins are inputs after reset.
// [RL9] Mask register limits fast-group accesses to unmasked bits; fast direction writes and reads ignore the mask.
// [RL10] Fast-group registers take byte writes; one word write sets the whole port.
// [RL11] Legacy and fast register groups control the same pins.
// [RL12] Software never enables both serial controllers sharing the pins at once.
// [RL13] Slave-select input is not needed by the serial controller in master mode.
// [RL14] Software writes only listed field encodings; others are reserved.
package pfm_pkg;

   // Register byte addresses.
   localparam logic [31:0] PFM_SEL_HIGH_ADDR  = 32'hE002_C004;
   localparam logic [31:0] PFM_LEG_VALUE_ADDR = 32'hE002_8000;
   localparam logic [31:0] PFM_LEG_SET_ADDR   = 32'hE002_8004;
   localparam logic [31:0] PFM_LEG_DIR_ADDR   = 32'hE002_8008;
   localparam logic [31:0] PFM_LEG_CLR_ADDR   = 32'hE002_800C;
   localparam logic [31:0] PFM_FAST_DIR_ADDR  = 32'hE002_D000;
   localparam logic [31:0] PFM_FAST_MASK_ADDR = 32'hE002_D010;
   localparam logic [31:0] PFM_FAST_PIN_ADDR  = 32'hE002_D014;
   localparam logic [31:0] PFM_FAST_SET_ADDR  = 32'hE002_D018;
   localparam logic [31:0] PFM_FAST_CLR_ADDR  = 32'hE002_D01C;

   // Reset values.
   localparam logic [31:0] PFM_SEL_RESET  = 32'h0000_0000;
   localparam logic [31:0] PFM_DIR_RESET  = 32'h0000_0000;
   localparam logic [31:0] PFM_OUT_RESET  = 32'h0000_0000;
   localparam logic [31:0] PFM_MASK_RESET = 32'h0000_0000;
   localparam logic        PFM_DEBUG_RESET = 1'b1;

   // Strap capture: clock edge after reset release at which the synchronised level is taken.
   // The second synchroniser stage first holds the pin level after edge 2, so edge 3 takes it.
   localparam logic [1:0] PFM_STRAP_EDGE = 2'h3;

   // Field encodings and pin layout.
   localparam logic [1:0] PFM_FSEL_GPIO = 2'h0;
   localparam logic [1:0] PFM_FSEL_ALT1 = 2'h1;
   localparam logic [1:0] PFM_FSEL_ALT2 = 2'h2;
   localparam int unsigned PFM_FIRST_PIN  = 16;
   localparam int unsigned PFM_GATED_PIN  = 17;
   localparam int unsigned PFM_TRACE_LAST = 26;
   localparam int unsigned PFM_TDO_PIN    = 31;
   localparam int unsigned PFM_TRACE_W    = 10;

   // Pins whose encoding 01 is an input, 01 an output, 10 an output.
   localparam logic [31:0] PFM_ALT1_IN_PINS  = 32'h7807_0000;
   localparam logic [31:0] PFM_ALT1_OUT_PINS = 32'h8038_0000;
   localparam logic [31:0] PFM_ALT2_OUT_PINS = 32'h0001_0000;

   typedef enum logic [1:0] {KIND_GPIO, KIND_IN, KIND_OUT, KIND_RSVD} pfm_kind_e;

   // Kind of function that a field value gives a pin.
   function automatic pfm_kind_e pfm_kind(input int unsigned pin, input logic [1:0] fsel);
      pfm_kind_e k;
      k = KIND_RSVD;
      case (fsel)
         PFM_FSEL_GPIO: k = KIND_GPIO;
         PFM_FSEL_ALT1: begin
            if (PFM_ALT1_IN_PINS[pin[4:0]]) k = KIND_IN;
            else if (PFM_ALT1_OUT_PINS[pin[4:0]]) k = KIND_OUT;
         end
         PFM_FSEL_ALT2: begin
            if (PFM_ALT2_OUT_PINS[pin[4:0]]) k = KIND_OUT;
         end
         default: k = KIND_RSVD;
      endcase
      return k;
   endfunction

   // Expands byte strobes to a bit mask.
   function automatic logic [31:0] pfm_lanes(input logic [3:0] strb);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) m[8*b +: 8] = 8'hFF;
      end
      return m;
   endfunction

endpackage : pfm_pkg

//--- hw/pfm_upper_mux.sv
// Pin function multiplexer for port pins 16..31 plus the port I/O registers.
// Assumes an APB4 master on pclk, pad levels arriving asynchronously, and
// peripherals that sit on pclk.
module pfm_upper_mux
   import pfm_pkg::*;
(
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Pads.
   input  wire logic [31:0] pad_in,
   output logic [31:0]      pad_out,
   output logic [31:0]      pad_oe,
   // Debug strap and debug ports.
   input  wire logic        debug_select_input,
   output logic             primary_debug_enable,
   input  wire logic [9:0]  trace_data,
   input  wire logic        jtag_tdo,
   output logic             jtag_trst,
   output logic             jtag_tms,
   output logic             jtag_tck,
   output logic             jtag_tdi,
   // Peripheral outputs toward the pins.
   input  wire logic        timer0_match2,
   input  wire logic        timer1_match2,
   input  wire logic        timer1_match3,
   input  wire logic        pulse_output_five,
   // Peripheral inputs from the pins.
   output logic             external_interrupt_line_0,
   output logic             timer1_capture2,
   output logic             timer1_capture3,
   // Serial controller slave select.
   input  wire logic        spi_master_mode,
   input  wire logic        spi_select_pin,
   output logic             spi_slave_select
);

   // Synchronisers for pads, strap and slave select.
   logic [31:0] pad_meta;
   logic [31:0] pad_sync;
   logic        strap_meta;
   logic        strap_sync;
   logic        ssel_meta;
   logic        ssel_sync;
   logic [31:0] next_pad_meta;
   logic [31:0] next_pad_sync;
   logic        next_strap_meta;
   logic        next_strap_sync;
   logic        next_ssel_meta;
   logic        next_ssel_sync;

   always_comb begin
      next_pad_meta   = pad_in;
      next_pad_sync   = pad_meta;
      next_strap_meta = debug_select_input;
      next_strap_sync = strap_meta;
      next_ssel_meta  = spi_select_pin;
      next_ssel_sync  = ssel_meta;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_meta   <= 32'h0000_0000;
         pad_sync   <= 32'h0000_0000;
         strap_meta <= 1'b0;
         strap_sync <= 1'b0;
         ssel_meta  <= 1'b1;
         ssel_sync  <= 1'b1;
      end else begin
         pad_meta   <= next_pad_meta;
         pad_sync   <= next_pad_sync;
         strap_meta <= next_strap_meta;
         strap_sync <= next_strap_sync;
         ssel_meta  <= next_ssel_meta;
         ssel_sync  <= next_ssel_sync;
      end
   end

   // Debug strap: the level is caught once, shortly after reset release, and then frozen.
   logic [1:0] strap_cnt;
   logic       debug_mode;
   logic [1:0] next_strap_cnt;
   logic       next_debug_mode;

   always_comb begin
      next_strap_cnt  = strap_cnt;
      next_debug_mode = debug_mode;
      if (strap_cnt != PFM_STRAP_EDGE) begin
         next_strap_cnt = strap_cnt + 2'h1;
         if (strap_cnt + 2'h1 == PFM_STRAP_EDGE) next_debug_mode = strap_sync; // RL3
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_cnt  <= 2'h0;
         debug_mode <= PFM_DEBUG_RESET;
      end else begin
         strap_cnt  <= next_strap_cnt;
         debug_mode <= next_debug_mode;
      end
   end

   // Register file.
   logic [31:0] sel_high;
   logic [31:0] dir_reg;
   logic [31:0] out_reg;
   logic [31:0] mask_reg;
   logic [31:0] next_sel_high;
   logic [31:0] next_dir_reg;
   logic [31:0] next_out_reg;
   logic [31:0] next_mask_reg;
   logic [31:0] lanes;
   logic [31:0] fast_bits;
   logic        access;
   logic        mapped;

   function automatic logic addr_mapped(input logic [31:0] a);
      return a == PFM_SEL_HIGH_ADDR || a == PFM_LEG_VALUE_ADDR || a == PFM_LEG_SET_ADDR ||
             a == PFM_LEG_DIR_ADDR || a == PFM_LEG_CLR_ADDR || a == PFM_FAST_DIR_ADDR ||
             a == PFM_FAST_MASK_ADDR || a == PFM_FAST_PIN_ADDR || a == PFM_FAST_SET_ADDR ||
             a == PFM_FAST_CLR_ADDR;
   endfunction

   assign pready  = 1'b1;
   assign access  = psel && penable;
   assign mapped  = addr_mapped(paddr);
   assign pslverr = access && !mapped;

   always_comb begin
      next_sel_high = sel_high;
      next_dir_reg  = dir_reg;
      next_out_reg  = out_reg;
      next_mask_reg = mask_reg;
      lanes         = pfm_lanes(pstrb);
      fast_bits     = pwdata & lanes & ~mask_reg; // RL9 RL10
      if (access && pwrite) begin
         case (paddr)
            PFM_SEL_HIGH_ADDR:  next_sel_high = pwdata; // RL1
            PFM_LEG_VALUE_ADDR: next_out_reg  = pwdata; // RL11
            PFM_LEG_SET_ADDR:   next_out_reg  = out_reg | pwdata; // RL6
            PFM_LEG_CLR_ADDR:   next_out_reg  = out_reg & ~pwdata; // RL6
            PFM_LEG_DIR_ADDR:   next_dir_reg  = pwdata; // RL11
            PFM_FAST_DIR_ADDR:  next_dir_reg  = (dir_reg & ~lanes) | (pwdata & lanes); // RL10
            PFM_FAST_MASK_ADDR: next_mask_reg = (mask_reg & ~lanes) | (pwdata & lanes); // RL10
            PFM_FAST_PIN_ADDR: begin
               next_out_reg = (out_reg & ~(lanes & ~mask_reg)) | fast_bits; // RL9 RL10
            end
            PFM_FAST_SET_ADDR:  next_out_reg  = out_reg | fast_bits; // RL6 RL9
            PFM_FAST_CLR_ADDR:  next_out_reg  = out_reg & ~fast_bits; // RL6 RL9
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_high <= PFM_SEL_RESET; // RL1
         dir_reg  <= PFM_DIR_RESET; // RL8
         out_reg  <= PFM_OUT_RESET;
         mask_reg <= PFM_MASK_RESET;
      end else begin
         sel_high <= next_sel_high;
         dir_reg  <= next_dir_reg;
         out_reg  <= next_out_reg;
         mask_reg <= next_mask_reg;
      end
   end

   // Read data is taken in the setup cycle so the access phase needs no wait.
   logic [31:0] next_prdata;

   always_comb begin
      next_prdata = prdata;
      if (psel && !penable && !pwrite) begin
         case (paddr)
            PFM_SEL_HIGH_ADDR:  next_prdata = sel_high;
            PFM_LEG_VALUE_ADDR: next_prdata = pad_sync; // RL7
            PFM_LEG_SET_ADDR:   next_prdata = out_reg; // RL7
            PFM_LEG_DIR_ADDR:   next_prdata = dir_reg;
            PFM_FAST_DIR_ADDR:  next_prdata = dir_reg; // RL11
            PFM_FAST_MASK_ADDR: next_prdata = mask_reg;
            PFM_FAST_PIN_ADDR:  next_prdata = pad_sync & ~mask_reg; // RL7 RL9
            PFM_FAST_SET_ADDR:  next_prdata = out_reg & ~mask_reg; // RL7 RL9
            default:            next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h0000_0000;
      else prdata <= next_prdata;
   end

   // Pad and peripheral routing.
   pfm_kind_e   kind;
   logic [1:0]  fsel;
   logic [31:0] periph_out;
   logic [31:0] in_sel;
   logic [31:0] next_pad_out;
   logic [31:0] next_pad_oe;
   logic        next_external_interrupt_line_0;
   logic        next_cap2;
   logic        next_cap3;
   logic        next_trst;
   logic        next_tms;
   logic        next_tck;
   logic        next_tdi;
   logic        next_ssel;

   always_comb begin
      kind         = KIND_GPIO;
      fsel         = PFM_FSEL_GPIO;
      periph_out   = 32'h0000_0000;
      periph_out[16] = timer0_match2;
      periph_out[19] = timer1_match2;
      periph_out[20] = timer1_match3;
      periph_out[21] = pulse_output_five;
      periph_out[31] = jtag_tdo;
      in_sel       = 32'h0000_0000;
      next_pad_out = 32'h0000_0000;
      next_pad_oe  = 32'h0000_0000;
      next_pad_out[15:0] = out_reg[15:0];
      next_pad_oe[15:0]  = dir_reg[15:0]; // RL2 RL8
      for (int i = PFM_FIRST_PIN; i < 32; i++) begin
         fsel = sel_high[2*(i-PFM_FIRST_PIN) +: 2];
         if (i >= PFM_GATED_PIN && debug_mode) begin
            // Debug mode ignores the fields: trace out, then JTAG.
            // Outputs stay undriven until the strap is caught, so a low strap never contends.
            if (i <= PFM_TRACE_LAST || i == PFM_TDO_PIN) begin
               kind = (strap_cnt == PFM_STRAP_EDGE) ? KIND_OUT : KIND_RSVD; // RL4 RL8
            end else begin
               kind = KIND_IN; // RL4
            end
         end else begin
            kind = pfm_kind(i, fsel); // RL5 RL14
         end
         case (kind)
            KIND_GPIO: begin
               next_pad_out[i] = out_reg[i];
               next_pad_oe[i]  = dir_reg[i]; // RL2
            end
            KIND_OUT: begin
               next_pad_oe[i] = 1'b1; // RL2
               if (debug_mode && i >= PFM_GATED_PIN && i <= PFM_TRACE_LAST) begin
                  next_pad_out[i] = trace_data[i-PFM_GATED_PIN];
               end else begin
                  next_pad_out[i] = periph_out[i];
               end
            end
            KIND_IN: in_sel[i] = 1'b1; // RL2
            default: begin
            end
         endcase
      end
      next_external_interrupt_line_0 = in_sel[16] & pad_sync[16];
      next_cap2  = in_sel[17] & pad_sync[17]; // RL5
      next_cap3  = in_sel[18] & pad_sync[18]; // RL5
      next_trst  = in_sel[27] & pad_sync[27];
      next_tms   = in_sel[28] & pad_sync[28];
      next_tck   = in_sel[29] & pad_sync[29];
      next_tdi   = in_sel[30] & pad_sync[30];
      next_ssel  = spi_master_mode ? 1'b1 : ssel_sync; // RL13
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_out                   <= 32'h0000_0000;
         pad_oe                    <= 32'h0000_0000; // RL8
         external_interrupt_line_0 <= 1'b0;
         timer1_capture2           <= 1'b0;
         timer1_capture3           <= 1'b0;
         jtag_trst                 <= 1'b0;
         jtag_tms                  <= 1'b0;
         jtag_tck                  <= 1'b0;
         jtag_tdi                  <= 1'b0;
         spi_slave_select          <= 1'b1;
         primary_debug_enable      <= 1'b0;
      end else begin
         pad_out                   <= next_pad_out;
         pad_oe                    <= next_pad_oe;
         external_interrupt_line_0 <= next_external_interrupt_line_0;
         timer1_capture2           <= next_cap2;
         timer1_capture3           <= next_cap3;
         jtag_trst                 <= next_trst;
         jtag_tms                  <= next_tms;
         jtag_tck                  <= next_tck;
         jtag_tdi                  <= next_tdi;
         spi_slave_select          <= next_ssel;
         primary_debug_enable      <= debug_mode && strap_cnt == PFM_STRAP_EDGE; // RL3
      end
   end

endmodule // pfm_upper_mux

//--- verification/pfm_upper_mux_chk.sv
// Concurrent checks on the ports of the upper pin function multiplexer.
// Assumes one pclk domain and an APB master that stays idle while reset settles.
module pfm_upper_mux_chk
   import pfm_pkg::*;
(
   // Clock and reset.
   input wire logic        pclk,
   input wire logic        presetn,
   // APB request.
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   // Pads and debug.
   input wire logic [31:0] pad_out,
   input wire logic [31:0] pad_oe,
   input wire logic        primary_debug_enable,
   input wire logic [9:0]  trace_data,
   // Peripheral side.
   input wire logic        timer1_capture2,
   input wire logic        timer1_capture3,
   input wire logic        spi_master_mode,
   input wire logic        spi_slave_select
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [2:0] since_rst;
   logic [2:0] next_since_rst;
   logic       wr;
   assign wr = psel && penable && pwrite;
   // Counts edges after reset so the strap is judged only once it has been caught.
   always_comb begin
      next_since_rst = since_rst;
      if (since_rst != 3'h5) next_since_rst = since_rst + 3'h1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) since_rst <= 3'h0;
      else since_rst <= next_since_rst;
   end
   property p_master; spi_master_mode |=> spi_slave_select; endproperty
   a_master: assert property (p_master) else $error("slave select low in master mode");
   property p_oe_rst; $rose(presetn) |-> pad_oe == 32'h0000_0000; endproperty
   a_oe_rst: assert property (p_oe_rst) else $error("pin driven after reset");
   property p_strap; since_rst == 3'h5 |-> $stable(primary_debug_enable); endproperty
   a_strap: assert property (p_strap) else $error("debug enable moved after capture");
   property p_dbg_cap; primary_debug_enable |-> !timer1_capture2 && !timer1_capture3; endproperty
   a_dbg_cap: assert property (p_dbg_cap) else $error("capture routed in debug mode");
   property p_dbg_oe;
      primary_debug_enable |-> pad_oe[26:17] == 10'h3FF && pad_oe[30:27] == 4'h0;
   endproperty
   a_dbg_oe: assert property (p_dbg_oe) else $error("debug pin direction wrong");
   property p_trace;
      primary_debug_enable && $past(primary_debug_enable) |-> pad_out[26:17] == $past(trace_data);
   endproperty
   a_trace: assert property (p_trace) else $error("trace level not on pins");
   property p_set;
      wr && paddr == PFM_LEG_SET_ADDR |=> ##1
         (pad_out[15:0] & pad_oe[15:0] & $past(pwdata[15:0], 2)) ==
         (pad_oe[15:0] & $past(pwdata[15:0], 2));
   endproperty
   a_set: assert property (p_set) else $error("set write missed a pin");
   property p_clr;
      wr && paddr == PFM_LEG_CLR_ADDR |=> ##1
         (pad_out[15:0] & pad_oe[15:0] & $past(pwdata[15:0], 2)) == 16'h0000;
   endproperty
   a_clr: assert property (p_clr) else $error("clear write missed a pin");
   property p_oe_cause;
      !$stable(pad_oe[15:0]) |->
         $past(wr && (paddr == PFM_LEG_DIR_ADDR || paddr == PFM_FAST_DIR_ADDR), 2);
   endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("direction moved unasked");
   c_sel: cover property (wr && paddr == PFM_SEL_HIGH_ADDR);
   c_dbg: cover property (primary_debug_enable);
   c_cap: cover property (timer1_capture2);
endmodule // pfm_upper_mux_chk

bind pfm_upper_mux pfm_upper_mux_chk u_pfm_upper_mux_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pad_out, .pad_oe, .primary_debug_enable, .trace_data,
   .timer1_capture2, .timer1_capture3, .spi_master_mode, .spi_slave_select);

//--- verification/pfm_pins.sv
// Board model for the port pins: device drive wins, then the bench's drive.
// Assumes one pclk; a floating pin must never read as a steady level.
module pfm_pins (
   // Clock.
   input  wire logic        pclk,
   // Device drive.
   input  wire logic [31:0] pad_out,
   input  wire logic [31:0] pad_oe,
   // Bench drive.
   input  wire logic [31:0] ext_val,
   input  wire logic [31:0] ext_en,
   // Pin levels.
   output logic [31:0]      pad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] float_pat = 32'h5555_5555;
   always @(posedge pclk) float_pat <= ~float_pat;
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                 | (~pad_oe & ~ext_en & float_pat);
endmodule // pfm_pins

//--- verification/test_port_upper_pin_function_mux.sv
// Self-checking bench for the upper pin function multiplexer.
// Assumes the APB slave and the board model pfm_pins.
module test_port_upper_pin_function_mux import pfm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [31:0] paddr, pwdata, prdata, rd, pad_in, pad_out, pad_oe, ext_val, ext_en;
   logic [3:0]  pstrb;
   logic [15:0] cnt = 16'h0000;
   logic [15:0] prev;
   logic [9:0]  trace_data;
   logic        debug_select_input, primary_debug_enable, jtag_tdo, jtag_trst, jtag_tms;
   logic        jtag_tck, jtag_tdi, timer0_match2, timer1_match2, timer1_match3;
   logic        pulse_output_five, external_interrupt_line_0, timer1_capture2;
   logic        timer1_capture3, spi_master_mode, spi_select_pin, spi_slave_select;
   int          n_fail, checked, cyc;
   assign trace_data = cnt[9:0];
   assign {jtag_tdo, timer0_match2, timer1_match2, timer1_match3} = cnt[3:0];
   assign pulse_output_five = cnt[4];
   // Peripheral levels that the pins registered at the last edge.
   assign prev = cnt - 16'h0001;
   pfm_upper_mux u_pfm_upper_mux (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .pready, .prdata, .pslverr, .pad_in, .pad_out, .pad_oe,
      .debug_select_input, .primary_debug_enable, .trace_data, .jtag_tdo, .jtag_trst,
      .jtag_tms, .jtag_tck, .jtag_tdi, .timer0_match2, .timer1_match2, .timer1_match3,
      .pulse_output_five, .external_interrupt_line_0, .timer1_capture2, .timer1_capture3,
      .spi_master_mode, .spi_select_pin, .spi_slave_select);
   pfm_pins u_pfm_pins (.pclk, .pad_out, .pad_oe, .ext_val, .ext_en, .pad_in);
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cnt <= cnt + 16'h0001;
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         wrap_up();
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask
   task automatic rst(input logic strap);
      @(posedge pclk);
      presetn <= 1'b0;
      debug_select_input <= strap;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      wt(6);
   endtask
   task automatic t_reset;
      chk("pad_oe", 32'h0000_0000, pad_oe);
      apb(1'b0, PFM_SEL_HIGH_ADDR, 32'h0, 4'hF);
      chk("select", 32'h0000_0000, rd);
      apb(1'b0, PFM_LEG_DIR_ADDR, 32'h0, 4'hF);
      chk("dir", 32'h0000_0000, rd);
      $display("t_reset done");
   endtask
   task automatic t_gpio;
      apb(1'b1, PFM_LEG_DIR_ADDR, 32'h0002_00FF, 4'hF);
      apb(1'b1, PFM_LEG_VALUE_ADDR, 32'h0000_0000, 4'hF);
      apb(1'b1, PFM_LEG_SET_ADDR, 32'h0000_000F, 4'hF);
      apb(1'b1, PFM_LEG_CLR_ADDR, 32'h0000_0005, 4'hF);
      wt(2);
      chk("pad_out", 32'h0A, {24'h0, pad_out[7:0]});
      chk("pad_oe", 32'h0002_00FF, pad_oe);
      apb(1'b0, PFM_LEG_SET_ADDR, 32'h0, 4'hF);
      chk("out reg", 32'h0000_000A, rd);
      apb(1'b0, PFM_LEG_VALUE_ADDR, 32'h0, 4'hF);
      chk("pin level", 32'h0A, {24'h0, rd[7:0]});
      $display("t_gpio done");
   endtask
   task automatic t_capture;
      @(posedge pclk);
      ext_en <= 32'h0007_0000;
      ext_val <= 32'h0003_0000;
      apb(1'b1, PFM_SEL_HIGH_ADDR, 32'h0000_0015, 4'hF);
      wt(5);
      chk("pin17 oe", 32'h0, {31'h0, pad_oe[17]});
      chk("captures", 32'h1, {30'h0, timer1_capture3, timer1_capture2});
      chk("eint", 32'h1, {31'h0, external_interrupt_line_0});
      @(posedge pclk);
      ext_val <= 32'h0004_0000;
      wt(5);
      chk("captures", 32'h2, {30'h0, timer1_capture3, timer1_capture2});
      chk("eint", 32'h0, {31'h0, external_interrupt_line_0});
      apb(1'b0, PFM_SEL_HIGH_ADDR, 32'h0, 4'hF);
      chk("select", 32'h0000_0015, rd);
      @(posedge pclk);
      ext_en <= 32'h0800_0000;
      ext_val <= 32'h0800_0000;
      apb(1'b1, PFM_SEL_HIGH_ADDR, 32'h0040_0042, 4'hF);
      wt(5);
      chk("alt oe", 32'h0009_0000, pad_oe & 32'h0809_0000);
      chk("trst", 32'h1, {31'h0, jtag_trst});
      chk("alt out", {30'h0, prev[1], prev[2]}, {30'h0, pad_out[19], pad_out[16]});
      $display("t_capture done");
   endtask
   task automatic t_fast;
      apb(1'b1, PFM_FAST_MASK_ADDR, 32'hFFFF_FF00, 4'hF);
      apb(1'b1, PFM_FAST_PIN_ADDR, 32'hFFFF_FF55, 4'h1);
      apb(1'b1, PFM_FAST_CLR_ADDR, 32'hFFFF_FF01, 4'hF);
      wt(2);
      chk("pad_out", 32'h54, {24'h0, pad_out[7:0]});
      apb(1'b0, PFM_FAST_SET_ADDR, 32'h0, 4'hF);
      chk("fast out", 32'h0000_0054, rd);
      apb(1'b1, PFM_FAST_MASK_ADDR, 32'h0000_0000, 4'hF);
      apb(1'b1, PFM_FAST_PIN_ADDR, 32'h0000_AAFF, 4'h2);
      apb(1'b0, PFM_LEG_SET_ADDR, 32'h0, 4'hF);
      chk("lane write", 32'h0000_AA54, rd);
      apb(1'b1, PFM_FAST_PIN_ADDR, 32'h1234_5678, 4'hF);
      apb(1'b0, PFM_LEG_SET_ADDR, 32'h0, 4'hF);
      chk("word write", 32'h1234_5678, rd);
      $display("t_fast done");
   endtask
   task automatic t_misc;
      @(posedge pclk);
      spi_master_mode <= 1'b1;
      spi_select_pin <= 1'b0;
      wt(4);
      chk("slave select", 32'h1, {31'h0, spi_slave_select});
      @(posedge pclk);
      spi_master_mode <= 1'b0;
      wt(4);
      chk("slave select", 32'h0, {31'h0, spi_slave_select});
      apb(1'b0, 32'hE002_8010, 32'h0, 4'hF);
      chk("unmapped", 32'h0000_0001, {31'h0, er});
      chk("unmapped data", 32'h0, rd);
      $display("t_misc done");
   endtask
   task automatic t_debug;
      rst(1'b1);
      chk("debug enable", 32'h1, {31'h0, primary_debug_enable});
      apb(1'b1, PFM_SEL_HIGH_ADDR, 32'h5555_5554, 4'hF);
      wt(5);
      chk("trace oe", 32'h3FF, {22'h0, pad_oe[26:17]});
      chk("captures", 32'h0, {30'h0, timer1_capture3, timer1_capture2});
      chk("debug enable", 32'h1, {31'h0, primary_debug_enable});
      rst(1'b0);
      chk("debug enable", 32'h0, {31'h0, primary_debug_enable});
      $display("t_debug done");
   endtask
   task automatic wrap_up;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      {presetn, psel, penable, pwrite, debug_select_input} = 5'h00;
      {spi_master_mode, spi_select_pin, paddr, pwdata, pstrb} = '0;
      {ext_val, ext_en} = '0;
      rst(1'b0);
      t_reset();
      t_gpio();
      t_capture();
      t_fast();
      t_misc();
      t_debug();
      wrap_up();
   end
endmodule // test_port_upper_pin_function_mux
